// >>> core/atx_pkg.sv
// Shared constants and types for the serial transmit block
package atx_pkg;

    // ------------------------------------------------------------
    // Clocking and line timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_KHZ = 125000;
    localparam int MCLK_KHZ    = 1000;
    localparam int MCLK_DIV    = SYS_CLK_KHZ / MCLK_KHZ;  // System clocks per master tick

    // Master ticks per half bit and per word gap
    localparam logic [8:0] HS_HALF_TICKS = 9'h005;
    localparam logic [8:0] LS_HALF_TICKS = 9'h028;
    localparam logic [8:0] HS_GAP_TICKS  = 9'h028;
    localparam logic [8:0] LS_GAP_TICKS  = 9'h140;

    localparam logic [5:0] BITS_PER_WORD = 6'h20;
    localparam int         FIFO_DEPTH    = 32;
    localparam int         HALF_WORDS    = 16;

    // ------------------------------------------------------------
    // Register map (byte addresses) and field layout
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFS   = 8'h00;
    localparam logic [7:0] STATUS_OFFS = 8'h04;

    localparam int ST_READY_POS = 0;
    localparam int ST_HALF_POS  = 1;
    localparam int ST_FULL_POS  = 2;
    localparam int ST_BUSY_POS  = 3;
    localparam int ST_COUNT_POS = 8;

    typedef struct packed {
        logic speed_low;
        logic repeat_en;
        logic self_test_n_bit;
        logic parity_polarity_select;
        logic parity_enable_bit;
    } atx_ctrl_t;

    // Parity on, self test off, high speed
    localparam logic [4:0] CTRL_RESET = 5'h05;

    // Line pair levels {high leg, low leg}
    typedef logic [1:0] atx_line_t;
    localparam atx_line_t LINE_ONE  = 2'h2;
    localparam atx_line_t LINE_ZERO = 2'h1;
    localparam atx_line_t LINE_NULL = 2'h0;

    typedef enum logic [2:0] {
        ATX_IDLE,
        ATX_LOAD,
        ATX_DATA,
        ATX_NULL,
        ATX_GAP
    } atx_state_t;

endpackage

// >>> core/atx_word_mem.sv
// Word storage for the transmit FIFO, registered read data
`timescale 1ns/1ps
module atx_word_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    input  wire logic             clk_sys,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem_r [DEPTH];

    // ------------------------------------------------------------
    // Storage has no reset; pointers guard what is valid
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
        rd_data <= mem_r[rd_addr];
    end

endmodule

// >>> core/atx_tx_core.sv
// Serial transmit FIFO, serializer, self-test loopback and register slave
//
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module atx_tx_core #(
    parameter int DEPTH = atx_pkg::FIFO_DEPTH
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // Parallel load port
    input  wire logic [15:0] host_data_in,
    input  wire logic        load_low_byte_strobe_n,
    input  wire logic        load_high_byte_strobe_n,
    // Receiver read-out path used by repeater mode
    input  wire logic [15:0] rx_read_data,
    input  wire logic        rx_read_strobe_n,
    input  wire logic        rx_read_sel,
    // Control pins
    input  wire logic        tx_enable_in,
    input  wire logic        master_reset_in,
    // Receiver line inputs and what the receivers see
    input  wire logic [1:0]  line_rx1_in,
    input  wire logic [1:0]  line_rx2_in,
    output logic      [1:0]  rx1_serial,
    output logic      [1:0]  rx2_serial,
    // Serial line and flags
    output logic      [1:0]  serial_out_pair,
    output logic             tx_fifo_full_flag,
    output logic             tx_fifo_half_flag,
    output logic             tx_ready_flag
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
    localparam logic [CW-1:0] HALF_C  = CW'(atx_pkg::HALF_WORDS);

    // ------------------------------------------------------------
    // Register bus slave
    // ------------------------------------------------------------
    atx_pkg::atx_ctrl_t ctrl_r, ctrl_nxt;
    logic        wr_pend_r, wr_pend_nxt;
    logic [7:0]  wr_addr_r, wr_addr_nxt;
    logic [31:0] hrdata_nxt;
    logic [CW-1:0] count_r;
    atx_pkg::atx_state_t state_r;

    // Zero wait: reads answer at the edge closing the address phase
    always_comb begin
        ctrl_nxt    = ctrl_r;
        wr_pend_nxt = 1'b0;
        wr_addr_nxt = wr_addr_r;
        hrdata_nxt  = hrdata;
        if (wr_pend_r && wr_addr_r == atx_pkg::CTRL_OFFS) begin
            ctrl_nxt = atx_pkg::atx_ctrl_t'(hwdata[4:0]);  // master reset untouched
        end
        if (hsel && hready && htrans[1]) begin
            wr_pend_nxt = hwrite;
            wr_addr_nxt = haddr;
            hrdata_nxt  = 32'h0000_0000;
            if (!hwrite && haddr == atx_pkg::CTRL_OFFS) begin
                hrdata_nxt = {27'h000_0000, ctrl_r};
            end else if (!hwrite && haddr == atx_pkg::STATUS_OFFS) begin
                hrdata_nxt[atx_pkg::ST_READY_POS] = tx_ready_flag;
                hrdata_nxt[atx_pkg::ST_HALF_POS]  = tx_fifo_half_flag;
                hrdata_nxt[atx_pkg::ST_FULL_POS]  = tx_fifo_full_flag;
                hrdata_nxt[atx_pkg::ST_BUSY_POS]  = (state_r != atx_pkg::ATX_IDLE);
                hrdata_nxt[atx_pkg::ST_COUNT_POS +: CW] = count_r;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r    <= atx_pkg::atx_ctrl_t'(atx_pkg::CTRL_RESET);
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            ctrl_r    <= ctrl_nxt;
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            hrdata    <= hrdata_nxt;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Byte assembly and FIFO write side
    // ------------------------------------------------------------
    logic [2:0]    strb_prev_r, strb_prev_nxt;
    logic [15:0]   low_byte_r, low_byte_nxt;
    logic [AW-1:0] wr_ptr_r, wr_ptr_nxt;
    logic [AW-1:0] rd_ptr_r, rd_ptr_nxt;
    logic [CW-1:0] count_nxt;
    logic          full_nxt, half_nxt, ready_nxt;
    logic          low_ev, high_ev, rep_low, rep_high, push, pop;
    logic [31:0]   push_word, mem_rd_data;

    // Falling edges of the active-low strobes; repeater reads feed the same path
    always_comb begin
        strb_prev_nxt = {rx_read_strobe_n, load_high_byte_strobe_n, load_low_byte_strobe_n};
        rep_low  = ctrl_r.repeat_en && strb_prev_r[2] && !rx_read_strobe_n
                   && !rx_read_sel;
        rep_high = ctrl_r.repeat_en && strb_prev_r[2] && !rx_read_strobe_n
                   && rx_read_sel;
        low_ev   = (strb_prev_r[0] && !load_low_byte_strobe_n) || rep_low;
        high_ev  = (strb_prev_r[1] && !load_high_byte_strobe_n) || rep_high;
        low_byte_nxt = low_byte_r;
        if (rep_low) begin
            low_byte_nxt = rx_read_data;
        end else if (low_ev) begin
            low_byte_nxt = host_data_in;
        end
        push_word = {(rep_high ? rx_read_data : host_data_in), low_byte_r};
        if (ctrl_r.parity_enable_bit) begin
            push_word[31] = 1'b0;
        end
        push = high_ev && (count_r != DEPTH_C);
        pop  = (state_r == atx_pkg::ATX_IDLE) && tx_enable_in && (count_r != '0);
        wr_ptr_nxt = push ? wr_ptr_r + AW'(1) : wr_ptr_r;
        rd_ptr_nxt = pop ? rd_ptr_r + AW'(1) : rd_ptr_r;
        count_nxt  = count_r + CW'(push) - CW'(pop);
        if (master_reset_in) begin
            wr_ptr_nxt = '0;
            rd_ptr_nxt = '0;
            count_nxt  = '0;
        end
        full_nxt = (count_nxt == DEPTH_C);
        half_nxt = (count_nxt < HALF_C);
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            strb_prev_r       <= 3'h7;
            low_byte_r        <= 16'h0000;
            wr_ptr_r          <= '0;
            rd_ptr_r          <= '0;
            count_r           <= '0;
            tx_fifo_full_flag <= 1'b0;
            tx_fifo_half_flag <= 1'b1;
        end else begin
            strb_prev_r       <= strb_prev_nxt;
            low_byte_r        <= low_byte_nxt;
            wr_ptr_r          <= wr_ptr_nxt;
            rd_ptr_r          <= rd_ptr_nxt;
            count_r           <= count_nxt;
            tx_fifo_full_flag <= full_nxt;
            tx_fifo_half_flag <= half_nxt;
        end
    end

    atx_word_mem #(
        .WIDTH (32),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_mem (
        .clk_sys (clk_sys),
        .wr_en   (push),
        .wr_addr (wr_ptr_r),
        .wr_data (push_word),
        .rd_addr (rd_ptr_r),
        .rd_data (mem_rd_data)
    );

    // ------------------------------------------------------------
    // Master tick divider and serializer
    // ------------------------------------------------------------
    logic [7:0]  div_r, div_nxt;
    logic        tick;
    atx_pkg::atx_state_t state_nxt;
    logic [31:0] shift_r, shift_nxt;
    logic [5:0]  bits_r, bits_nxt;
    logic [8:0]  ticks_r, ticks_nxt;
    logic        slow_r, slow_nxt;
    logic [8:0]  half_len, gap_len;
    atx_pkg::atx_line_t line_nxt, tx_line;
    logic [1:0]  rx1_nxt, rx2_nxt;

    // Free-running divider; the first half bit may start mid-tick
    always_comb begin
        tick    = (div_r == 8'(atx_pkg::MCLK_DIV - 1));
        div_nxt = tick ? 8'h00 : div_r + 8'h01;
        half_len = slow_r ? atx_pkg::LS_HALF_TICKS : atx_pkg::HS_HALF_TICKS;
        gap_len  = slow_r ? atx_pkg::LS_GAP_TICKS : atx_pkg::HS_GAP_TICKS;
        state_nxt = state_r;
        shift_nxt = shift_r;
        bits_nxt  = bits_r;
        ticks_nxt = tick ? ticks_r + 9'h001 : ticks_r;
        slow_nxt  = slow_r;
        case (state_r)
            atx_pkg::ATX_IDLE: begin
                ticks_nxt = 9'h000;
                if (pop) begin
                    state_nxt = atx_pkg::ATX_LOAD;
                    slow_nxt  = ctrl_r.speed_low;
                end
            end
            atx_pkg::ATX_LOAD: begin
                shift_nxt = mem_rd_data;
                if (ctrl_r.parity_enable_bit) begin
                    shift_nxt[31] = ~^mem_rd_data[30:0]
                                    ^ ctrl_r.parity_polarity_select;
                end
                bits_nxt  = 6'h00;
                ticks_nxt = 9'h000;
                state_nxt = atx_pkg::ATX_DATA;
            end
            atx_pkg::ATX_DATA: begin
                if (tick && ticks_r == half_len - 9'h001) begin
                    ticks_nxt = 9'h000;
                    state_nxt = atx_pkg::ATX_NULL;
                end
            end
            atx_pkg::ATX_NULL: begin
                if (tick && ticks_r == half_len - 9'h001) begin
                    ticks_nxt = 9'h000;
                    shift_nxt = {1'b0, shift_r[31:1]};                  // First bit sent first
                    bits_nxt  = bits_r + 6'h01;
                    state_nxt = (bits_r == atx_pkg::BITS_PER_WORD - 6'h01)
                                ? atx_pkg::ATX_GAP : atx_pkg::ATX_DATA;
                end
            end
            atx_pkg::ATX_GAP: begin
                if (tick && ticks_r == gap_len - 9'h001) begin
                    state_nxt = atx_pkg::ATX_IDLE;
                end
            end
            default: begin
                state_nxt = atx_pkg::ATX_IDLE;
            end
        endcase
        if (master_reset_in) begin
            state_nxt = atx_pkg::ATX_IDLE;
        end
        // Null outside data halves keeps the line quiet in gaps
        line_nxt = atx_pkg::LINE_NULL;
        if (state_nxt == atx_pkg::ATX_DATA) begin
            line_nxt = shift_nxt[0] ? atx_pkg::LINE_ONE : atx_pkg::LINE_ZERO;
        end
        tx_line = line_nxt;
        // Loopback swaps legs for receiver two, so null stays null
        rx1_nxt = ctrl_r.self_test_n_bit ? line_rx1_in : tx_line;
        rx2_nxt = ctrl_r.self_test_n_bit ? line_rx2_in
                                          : {tx_line[0], tx_line[1]};
        ready_nxt = (count_nxt == '0) && (state_nxt == atx_pkg::ATX_IDLE);
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            div_r           <= 8'h00;
            state_r         <= atx_pkg::ATX_IDLE;
            shift_r         <= 32'h0000_0000;
            bits_r          <= 6'h00;
            ticks_r         <= 9'h000;
            slow_r          <= 1'b0;
            serial_out_pair <= atx_pkg::LINE_NULL;
            rx1_serial      <= 2'h0;
            rx2_serial      <= 2'h0;
            tx_ready_flag   <= 1'b1;
        end else begin
            div_r           <= div_nxt;
            state_r         <= state_nxt;
            shift_r         <= shift_nxt;
            bits_r          <= bits_nxt;
            ticks_r         <= ticks_nxt;
            slow_r          <= slow_nxt;
            serial_out_pair <= tx_line;
            rx1_serial      <= rx1_nxt;
            rx2_serial      <= rx2_nxt;
            tx_ready_flag   <= ready_nxt;
        end
    end

endmodule

// >>> test/atx_tx_core_properties.sv
// Checker for flag relations and serial line timing of the transmit block
`timescale 1ns/1ps
module atx_tx_core_properties (
    input wire logic       clk_sys,
    input wire logic       rst_b,
    input wire logic       load_high_byte_strobe_n,
    input wire logic       tx_enable_in,
    input wire logic       master_reset_in,
    input wire logic [1:0] serial_out_pair,
    input wire logic       tx_fifo_full_flag,
    input wire logic       tx_fifo_half_flag,
    input wire logic       tx_ready_flag
);
    // ------------------------------------------------------------
    // Run lengths of the line
    // ------------------------------------------------------------
    logic [15:0] null_run_r;
    logic [15:0] data_run_r;
    logic        fresh_r;

    // Fresh until the first data after a reset, since idle null has no fixed length
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            null_run_r <= 16'h0000;
            data_run_r <= 16'h0000;
            fresh_r    <= 1'b1;
        end else begin
            null_run_r <= (serial_out_pair != 2'h0) ? 16'h0000 :
                          ((&null_run_r) ? null_run_r : null_run_r + 16'h0001);
            data_run_r <= (serial_out_pair == 2'h0) ? 16'h0000 : data_run_r + 16'h0001;
            fresh_r    <= master_reset_in | (fresh_r & (serial_out_pair == 2'h0));
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    a_pair_legal: assert property (serial_out_pair != 2'h3)
        else $error("serial pair drives both legs");
    a_null_half: assert property (serial_out_pair != 2'h0 && $past(serial_out_pair) == 2'h0
        && !fresh_r |-> null_run_r == 16'h0271 || null_run_r >= 16'h1388)
        else $error("null half or word gap has wrong length");
    a_data_half: assert property (serial_out_pair == 2'h0 && $past(serial_out_pair) != 2'h0
        && !$past(master_reset_in) |-> data_run_r >= 16'h01f4 && data_run_r <= 16'h0271)
        else $error("data half has wrong length");
    a_full_half: assert property (tx_fifo_full_flag |-> !tx_fifo_half_flag)
        else $error("full and half flags disagree");
    a_ready_empty: assert property (tx_ready_flag |-> tx_fifo_half_flag && !tx_fifo_full_flag)
        else $error("ready flag with words stored");
    a_ready_busy: assert property (serial_out_pair != 2'h0 |-> !tx_ready_flag)
        else $error("ready flag while sending");
    a_mreset_clear: assert property (master_reset_in |=> !tx_fifo_full_flag
        && tx_fifo_half_flag && serial_out_pair == 2'h0)
        else $error("master reset left flags or line set");
    a_full_drop: assert property (tx_fifo_full_flag && !tx_enable_in && !master_reset_in
        && $fell(load_high_byte_strobe_n) |=> tx_fifo_full_flag)
        else $error("load into full store changed full flag");
    a_first_bit: assert property ($rose(tx_enable_in) && fresh_r && !tx_ready_flag
        && !master_reset_in |-> ##[1:312] serial_out_pair != 2'h0)
        else $error("first bit late after enable");
endmodule

bind atx_tx_core atx_tx_core_properties u_atx_tx_core_properties (
    .clk_sys, .rst_b, .load_high_byte_strobe_n, .tx_enable_in, .master_reset_in,
    .serial_out_pair, .tx_fifo_full_flag, .tx_fifo_half_flag, .tx_ready_flag
);

// >>> test/atx_line_model.sv
// Behavioural line receiver that decodes the serial pair and checks loopback pairs
`timescale 1ns/1ps
module atx_line_model (
    input  wire logic [0:0]  clk_sys,
    input  wire logic [1:0]  line_pair,
    input  wire logic [1:0]  rx1_pair,
    input  wire logic [1:0]  rx2_pair,
    output logic      [31:0] word_seen,
    output int               word_cnt,
    output int               loop_bad
);
    logic [31:0] shift_q;
    int          nbits;

    // Sample mid data half; a short first half still leaves a wide margin
    initial begin
        word_seen = 32'h0000_0000;
        word_cnt  = 0;
        loop_bad  = 0;
        shift_q   = 32'h0000_0000;
        nbits     = 0;
        forever begin
            @(posedge clk_sys);
            if (line_pair == 2'h2 || line_pair == 2'h1) begin
                repeat (250) @(posedge clk_sys);
                shift_q = {line_pair == 2'h2, shift_q[31:1]};
                if (rx1_pair !== line_pair || rx2_pair !== {line_pair[0], line_pair[1]}) begin
                    loop_bad++;
                end
                nbits++;
                if (nbits == 32) begin
                    word_seen = shift_q;
                    word_cnt++;
                    nbits = 0;
                end
                while (line_pair != 2'h0) @(posedge clk_sys);
            end
        end
    end
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the serial transmit block
`timescale 1ns/1ps
module tb_top;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic        clk_sys, rst_b, hsel, hwrite, hready, hreadyout, hresp;
    logic [7:0]  haddr;
    logic [1:0]  htrans, line_rx1_in, line_rx2_in, rx1_serial, rx2_serial, serial_out_pair;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd_q, word_seen;
    logic [15:0] host_data_in, rx_read_data;
    logic        load_low_byte_strobe_n, load_high_byte_strobe_n, rx_read_strobe_n, rx_read_sel;
    logic        tx_enable_in, master_reset_in, tx_fifo_full_flag, tx_fifo_half_flag, tx_ready_flag;
    int          error_cnt, checks_done, word_cnt, loop_bad;

    assign hready = hreadyout;
    atx_tx_core u_atx_tx_core (.*);
    atx_line_model u_atx_line_model (.clk_sys(clk_sys), .line_pair(serial_out_pair),
        .rx1_pair(rx1_serial), .rx2_pair(rx2_serial), .word_seen(word_seen),
        .word_cnt(word_cnt), .loop_bad(loop_bad));

    always #4 clk_sys = ~clk_sys;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Single word transfer; waits on hready, the timeout cuts a hang
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge clk_sys); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic load_word(input logic [31:0] w);
        @(posedge clk_sys);
        host_data_in <= w[15:0];
        load_low_byte_strobe_n <= 1'b0;
        @(posedge clk_sys);
        load_low_byte_strobe_n <= 1'b1;
        host_data_in <= w[31:16];
        load_high_byte_strobe_n <= 1'b0;
        @(posedge clk_sys);
        load_high_byte_strobe_n <= 1'b1;
        @(posedge clk_sys);
    endtask

    task automatic rx_pull(input logic sel, input logic [15:0] d);
        @(posedge clk_sys);
        rx_read_data <= d;
        rx_read_sel <= sel;
        rx_read_strobe_n <= 1'b0;
        @(posedge clk_sys);
        rx_read_strobe_n <= 1'b1;
        @(posedge clk_sys);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic s_regs;
        ahb(1'b0, atx_pkg::CTRL_OFFS, 32'h0000_0000, rd_q);
        check("ctrl reset", {27'h0, atx_pkg::CTRL_RESET}, rd_q);
        check("rx1 line path", {30'h0, line_rx1_in}, {30'h0, rx1_serial});
        check("rx2 line path", {30'h0, line_rx2_in}, {30'h0, rx2_serial});
        check("bus ready resp", 32'h2, {30'h0, hreadyout, hresp});
        ahb(1'b1, 8'h08, 32'hffff_ffff, rd_q);
        ahb(1'b0, 8'h08, 32'h0000_0000, rd_q);
        check("unmapped", 32'h0000_0000, rd_q);
        ahb(1'b1, atx_pkg::STATUS_OFFS, 32'hffff_ffff, rd_q);
        ahb(1'b0, atx_pkg::STATUS_OFFS, 32'h0000_0000, rd_q);
        check("status idle", 32'h1 << atx_pkg::ST_READY_POS | 32'h1 << atx_pkg::ST_HALF_POS, rd_q);
        ahb(1'b1, atx_pkg::CTRL_OFFS, 32'h0000_000b, rd_q);
    endtask

    // Fill past capacity: the extra word must be dropped
    task automatic s_fill;
        int k;
        for (int i = 1; i <= atx_pkg::FIFO_DEPTH + 1; i++) begin
            load_word(32'h0000_0000 + i);
            k = (i > atx_pkg::FIFO_DEPTH) ? atx_pkg::FIFO_DEPTH : i;
            check("half flag", {31'h0, k < atx_pkg::HALF_WORDS}, {31'h0, tx_fifo_half_flag});
            check("full flag", {31'h0, k == atx_pkg::FIFO_DEPTH}, {31'h0, tx_fifo_full_flag});
        end
        check("ready while stored", 32'h0, {31'h0, tx_ready_flag});
        ahb(1'b0, atx_pkg::STATUS_OFFS, 32'h0000_0000, rd_q);
        check("count", 32'h20, {26'h0, rd_q[atx_pkg::ST_COUNT_POS +: 6]});
    endtask

    task automatic s_mreset;
        @(posedge clk_sys);
        master_reset_in <= 1'b1;
        @(posedge clk_sys);
        master_reset_in <= 1'b0;
        @(posedge clk_sys);
        check("flags after reset", 32'h6, {29'h0, tx_ready_flag, tx_fifo_half_flag, tx_fifo_full_flag});
        ahb(1'b0, atx_pkg::CTRL_OFFS, 32'h0000_0000, rd_q);
        check("ctrl kept", 32'h0000_000b, rd_q);
    endtask

    // Repeated word then host word, even parity, loopback on, enable held
    task automatic s_send;
        logic [31:0] a;
        logic [31:0] b;
        int n;
        a = 32'h8000_0003;
        b = 32'h1234_5678;
        rx_pull(1'b0, a[15:0]);
        rx_pull(1'b1, a[31:16]);
        load_word(b);
        ahb(1'b0, atx_pkg::STATUS_OFFS, 32'h0000_0000, rd_q);
        check("count two", 32'h2, {26'h0, rd_q[atx_pkg::ST_COUNT_POS +: 6]});
        tx_enable_in <= 1'b1;
        for (n = 0; n < 50000 && word_cnt < 1; n++) @(posedge clk_sys);
        check("first word", {^a[30:0], a[30:0]}, word_seen);
        check("ready mid run", 32'h0, {31'h0, tx_ready_flag});
        for (n = 0; n < 50000 && word_cnt < 2; n++) @(posedge clk_sys);
        check("second word", {^b[30:0], b[30:0]}, word_seen);
        for (n = 0; n < 8000 && tx_ready_flag !== 1'b1; n++) @(posedge clk_sys);
        check("ready at end", 32'h1, {31'h0, tx_ready_flag});
        check("loopback", 32'h0, loop_bad);
        tx_enable_in <= 1'b0;
    endtask

    task automatic wrap_up;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        rst_b = 1'b0;
        {hsel, hwrite, htrans, haddr, hsize, hwdata} = '0;
        {host_data_in, rx_read_data, rx_read_sel, tx_enable_in, master_reset_in} = '0;
        {load_low_byte_strobe_n, load_high_byte_strobe_n, rx_read_strobe_n} = 3'h7;
        line_rx1_in = 2'h2;
        line_rx2_in = 2'h1;
        error_cnt = 0;
        checks_done = 0;
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
        s_regs;
        s_fill;
        s_mreset;
        s_send;
        wrap_up;
    end

    // Two words at high speed take about 90k cycles
    initial begin
        repeat (100000) @(posedge clk_sys);
        error_cnt++;
        wrap_up;
    end
endmodule
